/* core/cip_map.svh */
// Register map, field positions and timing constants of the interrupt priority controller.
// Assumes inclusion by the package and by the controller module only.
// Notes on behaviour
// - Compact table maps NMI, high, normal to 1,2,3
// - Protected write needs key within four instructions
// - Protected write without unlock is ignored
// - Base select and compact bits need unlock
// - Round-robin bit writes directly
// - Base select chooses after or at boot
// - Base select ignored when all memory boots
// - Fixed priority or round-robin among normal requests
// - NMI active flag set in handler, cleared on return
// - High active flag held through NMI preemption
// - Normal active flag held through any preemption
// - Return restores exactly the previous level
// - Priority pointer readable, writable, steers normal order
// - Elevated vector zero disables high level
// - Pointer vector lowest, next vector highest
// - Round-robin writes acknowledged vector into pointer
// - High preempts normal; NMI ignores enable, unpreemptable
`ifndef CIP_MAP_SVH
`define CIP_MAP_SVH
`define CIP_NVEC        32
`define CIP_IDX_CTRL    2'h0
`define CIP_IDX_STAT    2'h1
`define CIP_IDX_PTR     2'h2
`define CIP_IDX_ELEV    2'h3
`define CIP_ADR_HI      4'h0
`define CIP_B_BASE      6
`define CIP_B_CVT       5
`define CIP_B_RR        0
`define CIP_B_NMIEXE    7
`define CIP_B_HIEXE     1
`define CIP_B_NOEXE     0
`define CIP_RST_BYTE    8'h00
`define CIP_NMI_MASK    32'h0000_0002
`define CIP_CVT_NMI     8'h01
`define CIP_CVT_HIGH    8'h02
`define CIP_CVT_NORM    8'h03
`define CIP_UNLOCK_WIN  3'h4
`endif

/* core/cip_pkg.sv */
// Types shared by the interrupt priority controller and its bench.
// Assumes the map header sits beside it.
`include "cip_map.svh"
package cip_pkg;
    // Level that a presented request would enter.
    typedef enum logic [1:0] {
        CIP_LV_NONE = 2'b00,
        CIP_LV_NORM = 2'b01,
        CIP_LV_HIGH = 2'b10,
        CIP_LV_NMI  = 2'b11
    } cip_lvl_type;
    // Request presented to the processor core.
    typedef struct packed {
        logic        req;
        cip_lvl_type lvl;
        logic [7:0]  vec;
    } cip_req_type;
endpackage

/* core/cip_ctrl.sv */
// Interrupt priority controller: arbitration, level tracking, Wishbone registers.
// Assumes requests, enable and core strobes come from logic on core_clk.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "cip_map.svh"
module cip_ctrl (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // Wishbone slave, 8-bit registers in the low lane
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Interrupt sources and global enable
    input  wire logic [31:0]      irq_req,
    input  wire logic             gie,
    // Processor core side
    input  wire logic             int_ack,
    input  wire logic             ret_pulse,
    input  wire logic             unlock_key_pulse,
    input  wire logic             instr_retire,
    input  wire logic             boot_all,
    output cip_pkg::cip_req_type  core_req,
    output logic                  vector_base_boot
);
    import cip_pkg::*;

    logic        rr_r, cvt_r, base_r;
    logic        nmi_act_r, hi_act_r, no_act_r;
    logic [7:0]  ptr_r, elev_r;
    logic [2:0]  unlock_cnt_r;
    cip_req_type req_r, req_nxt;
    logic        ack_r;
    logic [31:0] dat_r;

    // Rotating scan: vector ptr+1 wins first, ptr itself comes last.
    function automatic logic [5:0] pick(input logic [31:0] p,
                                        input logic [4:0] ptr);
        logic [5:0] r;
        logic [4:0] k;
        r = 6'h00;
        for (int i = `CIP_NVEC; i >= 1; i--) begin
            k = ptr + 5'(i);
            if (p[k]) begin
                r = {1'b1, k};
            end
        end
        return r;
    endfunction

    // Bus decode.
    logic       bus_req, bus_wr, lane0, mapped, prot_ok;
    logic [1:0] idx;
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign idx     = wb_adr_i[3:2];
    assign mapped  = (wb_adr_i[7:4] == `CIP_ADR_HI);
    assign lane0   = wb_sel_i[0];
    assign bus_wr  = bus_req & wb_we_i & lane0 & mapped;
    assign prot_ok = (unlock_cnt_r != 3'h0);

    // Vector classes. Vector 0 is reset and never requests.
    logic [31:0] hi_hot, nmi_p, norm_p;
    logic [5:0]  nmi_pk, norm_pk;
    logic        hi_p;
    assign hi_hot = (elev_r[7:5] == 3'h0 && elev_r != 8'h00) ?
                    (32'h0000_0001 << elev_r[4:0]) : 32'h0000_0000;
    assign nmi_p  = irq_req & `CIP_NMI_MASK;
    assign norm_p = irq_req & ~`CIP_NMI_MASK & ~hi_hot & ~32'h0000_0001;
    assign hi_p   = |(irq_req & hi_hot & ~`CIP_NMI_MASK);
    assign nmi_pk  = pick(nmi_p, 5'h00);
    assign norm_pk = pick(norm_p, ptr_r[4:0]);

    // Arbitration: NMI ignores the enable and nothing preempts it.
    always_comb begin
        req_nxt = '{req: 1'b0, lvl: CIP_LV_NONE, vec: 8'h00};
        if (nmi_pk[5] && !nmi_act_r) begin
            req_nxt = '{req: 1'b1, lvl: CIP_LV_NMI,
                        vec: cvt_r ? `CIP_CVT_NMI : {3'h0, nmi_pk[4:0]}};
        end else if (gie && !nmi_act_r && hi_p && !hi_act_r) begin
            req_nxt = '{req: 1'b1, lvl: CIP_LV_HIGH,
                        vec: cvt_r ? `CIP_CVT_HIGH : elev_r};
        end else if (gie && !nmi_act_r && !hi_act_r && !no_act_r && norm_pk[5]) begin
            req_nxt = '{req: 1'b1, lvl: CIP_LV_NORM,
                        vec: cvt_r ? `CIP_CVT_NORM : {3'h0, norm_pk[4:0]}};
        end
    end

    // Presented request; dropped for one cycle after each acknowledge.
    // The raw vector is kept so round-robin sees it even in compact mode.
    logic [7:0] raw_r;
    logic       took;
    assign took = int_ack & req_r.req;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_r <= '{req: 1'b0, lvl: CIP_LV_NONE, vec: 8'h00};
            raw_r <= 8'h00;
        end else if (took) begin
            req_r <= '{req: 1'b0, lvl: CIP_LV_NONE, vec: 8'h00};
        end else begin
            req_r <= req_nxt;
            raw_r <= {3'h0, (req_nxt.lvl == CIP_LV_NMI) ? nmi_pk[4:0] : norm_pk[4:0]};
        end
    end
    assign core_req = req_r;

    // Level flags: return clears the innermost level, acknowledge enters one.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            nmi_act_r <= 1'b0;
            hi_act_r  <= 1'b0;
            no_act_r  <= 1'b0;
        end else begin
            if (ret_pulse) begin
                if (nmi_act_r) begin
                    nmi_act_r <= 1'b0;
                end else if (hi_act_r) begin
                    hi_act_r <= 1'b0;
                end else begin
                    no_act_r <= 1'b0;
                end
            end
            if (took) begin
                unique case (req_r.lvl)
                    CIP_LV_NMI:  nmi_act_r <= 1'b1;
                    CIP_LV_HIGH: hi_act_r  <= 1'b1;
                    CIP_LV_NORM: no_act_r  <= 1'b1;
                    CIP_LV_NONE: ;
                endcase
            end
        end
    end

    // Unlock window, counted in retired instructions; a fresh key restarts it.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            unlock_cnt_r <= 3'h0;
        end else if (unlock_key_pulse) begin
            unlock_cnt_r <= `CIP_UNLOCK_WIN;
        end else if (bus_wr && idx == `CIP_IDX_CTRL) begin
            unlock_cnt_r <= 3'h0;
        end else if (instr_retire && prot_ok) begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
        end
    end

    // Control register: round-robin is open, base and compact are guarded.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rr_r   <= 1'b0;
            cvt_r  <= 1'b0;
            base_r <= 1'b0;
        end else if (bus_wr && idx == `CIP_IDX_CTRL) begin
            rr_r <= wb_dat_i[`CIP_B_RR];
            if (prot_ok) begin
                cvt_r  <= wb_dat_i[`CIP_B_CVT];
                base_r <= wb_dat_i[`CIP_B_BASE];
            end
        end
    end

    // Pointer: software writes it; round-robin overwrites it on acknowledge.
    // A hardware update in the same cycle wins over the software write.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_r <= `CIP_RST_BYTE;
        end else if (took && rr_r && req_r.lvl == CIP_LV_NORM) begin
            ptr_r <= raw_r;
        end else if (bus_wr && idx == `CIP_IDX_PTR) begin
            ptr_r <= wb_dat_i[7:0];
        end
    end

    // Elevated vector number.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            elev_r <= `CIP_RST_BYTE;
        end else if (bus_wr && idx == `CIP_IDX_ELEV) begin
            elev_r <= wb_dat_i[7:0];
        end
    end

    // Effective vector base; a boot-only memory forces the default.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_base_boot <= 1'b0;
        end else begin
            vector_base_boot <= base_r & ~boot_all;
        end
    end

    // Bus answer: one wait state, unmapped reads give zero.
    logic [7:0] rd;
    always_comb begin
        rd = 8'h00;
        unique case (idx)
            `CIP_IDX_CTRL: begin
                rd[`CIP_B_BASE] = base_r;
                rd[`CIP_B_CVT]  = cvt_r;
                rd[`CIP_B_RR]   = rr_r;
            end
            `CIP_IDX_STAT: begin
                rd[`CIP_B_NMIEXE] = nmi_act_r;
                rd[`CIP_B_HIEXE]  = hi_act_r;
                rd[`CIP_B_NOEXE]  = no_act_r;
            end
            `CIP_IDX_PTR:  rd = ptr_r;
            `CIP_IDX_ELEV: rd = elev_r;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            dat_r <= (bus_req && mapped) ? {24'h00_0000, rd} : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Checks.
    AST_CVT_NORM: assert property (@(posedge core_clk) disable iff (!rst_b)
        (req_r.req && cvt_r && req_r.lvl == CIP_LV_NORM) |-> req_r.vec == `CIP_CVT_NORM)
        else $error("compact normal vector not 3");
    AST_WIN_LOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
        unlock_key_pulse |=> unlock_cnt_r == `CIP_UNLOCK_WIN)
        else $error("unlock window not four");
    AST_LOCKED: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus_wr && idx == `CIP_IDX_CTRL && !prot_ok) |=> $stable(cvt_r) && $stable(base_r))
        else $error("guarded bit changed while locked");
    AST_RR_OPEN: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus_wr && idx == `CIP_IDX_CTRL) |=> rr_r == $past(wb_dat_i[`CIP_B_RR]))
        else $error("round-robin write lost");
    AST_BASE: assert property (@(posedge core_clk) disable iff (!rst_b)
        boot_all ##1 boot_all |-> !vector_base_boot)
        else $error("base select honoured in all-boot memory");
    AST_NMI_RET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ret_pulse && nmi_act_r && !took) |=> !nmi_act_r && $stable(hi_act_r))
        else $error("return did not end NMI level alone");
    AST_NMI_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
        nmi_act_r [*2] |-> !(req_r.req && req_r.lvl != CIP_LV_NMI))
        else $error("request presented inside NMI handler");
    AST_RR_PTR: assert property (@(posedge core_clk) disable iff (!rst_b)
        (took && rr_r && req_r.lvl == CIP_LV_NORM) |=> ptr_r == $past(raw_r))
        else $error("pointer not updated on acknowledge");
    AST_ELEV_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
        (elev_r == 8'h00) [*2] |-> !(req_r.req && req_r.lvl == CIP_LV_HIGH))
        else $error("high level active with no elevated vector");

    // Compact table checks; the raw vector must never leak through in compact mode.
    AST_CVT_NMI: assert property (@(posedge core_clk) disable iff (!rst_b)
        (req_r.req && cvt_r && req_r.lvl == CIP_LV_NMI) |-> req_r.vec == `CIP_CVT_NMI)
        else $error("compact NMI vector not 1");
    AST_CVT_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
        (req_r.req && cvt_r && req_r.lvl == CIP_LV_HIGH) |-> req_r.vec == `CIP_CVT_HIGH)
        else $error("compact high vector not 2");

    // Protection checks: an open window lets the guarded bits through, a control write shuts it.
    AST_GUARD_OPEN: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus_wr && idx == `CIP_IDX_CTRL && prot_ok) |=>
            cvt_r == $past(wb_dat_i[`CIP_B_CVT]) && base_r == $past(wb_dat_i[`CIP_B_BASE]))
        else $error("unlocked write to guarded bits lost");
    AST_WIN_SHUT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus_wr && idx == `CIP_IDX_CTRL && !unlock_key_pulse) |=> !prot_ok)
        else $error("unlock window stayed open after a control write");
    AST_WIN_STEP: assert property (@(posedge core_clk) disable iff (!rst_b)
        (instr_retire && prot_ok && !unlock_key_pulse && !(bus_wr && idx == `CIP_IDX_CTRL))
            |=> unlock_cnt_r == $past(unlock_cnt_r) - 3'h1)
        else $error("unlock window not counted down per instruction");
    AST_BASE_SEL: assert property (@(posedge core_clk) disable iff (!rst_b)
        !boot_all |=> vector_base_boot == $past(base_r))
        else $error("vector base does not follow base select");

    // Level tracking checks: acknowledge enters a level, return leaves only the innermost.
    AST_NMI_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (took && req_r.lvl == CIP_LV_NMI) |=> nmi_act_r)
        else $error("NMI level not entered on acknowledge");
    AST_HI_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (took && req_r.lvl == CIP_LV_HIGH) |=> hi_act_r)
        else $error("high level not entered on acknowledge");
    AST_NO_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (took && req_r.lvl == CIP_LV_NORM) |=> no_act_r)
        else $error("normal level not entered on acknowledge");
    AST_HI_RET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ret_pulse && !nmi_act_r && hi_act_r && !took) |=> !hi_act_r && $stable(no_act_r))
        else $error("return did not end high level alone");
    AST_NO_RET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ret_pulse && !nmi_act_r && !hi_act_r && !took) |=> !no_act_r)
        else $error("return did not end normal level");
    AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!ret_pulse && !took) |=> $stable(nmi_act_r) && $stable(hi_act_r) && $stable(no_act_r))
        else $error("level flags moved without acknowledge or return");

    // Presentation checks: who may be offered to the core while a level runs.
    AST_NORM_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
        (nmi_act_r || hi_act_r || no_act_r) [*2] |-> !(req_r.req && req_r.lvl == CIP_LV_NORM))
        else $error("normal request presented inside a handler");
    AST_HI_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
        (nmi_act_r || hi_act_r) [*2] |-> !(req_r.req && req_r.lvl == CIP_LV_HIGH))
        else $error("high request presented inside a high or NMI handler");
    AST_GIE_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!gie) [*2] |-> !(req_r.req && req_r.lvl != CIP_LV_NMI))
        else $error("maskable request presented with interrupts disabled");
    AST_ONE_DROP: assert property (@(posedge core_clk) disable iff (!rst_b)
        took |=> !req_r.req)
        else $error("request not dropped after acknowledge");

    // Pointer checks: fixed mode leaves it to software, software writes land.
    AST_FIX_PTR: assert property (@(posedge core_clk) disable iff (!rst_b)
        (took && !rr_r && !(bus_wr && idx == `CIP_IDX_PTR)) |=> $stable(ptr_r))
        else $error("pointer moved by hardware in fixed mode");
    AST_PTR_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus_wr && idx == `CIP_IDX_PTR && !(took && rr_r && req_r.lvl == CIP_LV_NORM))
            |=> ptr_r == $past(wb_dat_i[7:0]))
        else $error("pointer write lost");
endmodule // cip_ctrl
`default_nettype wire

/* sim/cip_core_model.sv */
// Processor core stand-in that takes every presented interrupt request.
// Assumes it shares core_clk and rst_b with the controller.
`timescale 1ns/1ps
`default_nettype none
module cip_core_model (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Controller side
    input  wire cip_pkg::cip_req_type core_req,
    input  wire logic                 slow,
    output logic                      int_ack
);
    import cip_pkg::*;
    logic [1:0] wait_r;
    // Acknowledge after zero or three idle cycles; a slow core lets a winner change meanwhile.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r  <= 2'h0;
            int_ack <= 1'b0;
        end else if (int_ack || !core_req.req) begin
            wait_r  <= 2'h0;
            int_ack <= 1'b0;
        end else if (wait_r == (slow ? 2'h3 : 2'h0)) begin
            int_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule // cip_core_model
`default_nettype wire

/* sim/cip_ctrl_tb.sv */
// Self-checking bench of the interrupt priority controller.
// Assumes the package, the map header and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cip_ctrl_tb;
    import cip_pkg::*;
    logic        core_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0, gie = 1'b0;
    logic        slow = 1'b0, ret_pulse = 1'b0, unlock = 1'b0, retire = 1'b0, boot_all = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, lane = 4'h1;
    logic [31:0] dat = 32'h0000_0000, irq = 32'h0000_0000, rdat;
    logic        ack, int_ack, vbb;
    cip_req_type req;
    logic [7:0]  qd[$];
    logic [9:0]  qr[$];
    int          n_mismatch = 0, total_checks = 0, cycles = 0, seed = 32'hb73270f7, rnd;
    // The clock toggles every half period of 12.5 ns.
    always #12.5 core_clk = ~core_clk;
    cip_ctrl uut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_req(irq), .gie(gie), .int_ack(int_ack), .ret_pulse(ret_pulse),
        .unlock_key_pulse(unlock), .instr_retire(retire), .boot_all(boot_all),
        .core_req(req), .vector_base_boot(vbb));
    cip_core_model core (.core_clk(core_clk), .rst_b(rst_b), .core_req(req), .slow(slow),
        .int_ack(int_ack));
    task chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Answers are compared with the oldest note; a hang is cut off by the cycle ceiling.
    always @(posedge core_clk) begin
        if (ack === 1'b1 && !we && qd.size() > 0)
            chk("read", {1'b0, |rdat[31:8], rdat[7:0]}, {2'b00, qd.pop_front()});
        if (int_ack === 1'b1 && req.req === 1'b1)
            chk("vector", {req.lvl, req.vec}, (qr.size() > 0) ? qr.pop_front() : 10'h3ff);
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // Classic single cycle; the request is held until ack is sampled high.
    // A slave that never answers is left to the cycle ceiling, which counts it.
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (!w)
            qd.push_back(d);
        cyc <= 1'b1;
        we  <= w;
        sel <= lane;
        adr <= a;
        dat <= {24'h00_0000, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask
    // Raise request lines, note the expected winner and wait for the core to take it.
    task irq_go(input logic [31:0] v, input logic [9:0] e);
        int i;
        rnd = $random(seed);
        irq  <= v;
        slow <= rnd[0];
        qr.push_back(e);
        i = 0;
        do @(posedge core_clk); while (!(int_ack === 1'b1 && req.req === 1'b1) && ++i < 50);
        if (i == 50)
            n_mismatch++;
        @(posedge core_clk);
    endtask
    // One interrupt return from the core, then the level state is read.
    task ret_chk(input logic [7:0] s);
        ret_pulse <= 1'b1;
        @(posedge core_clk);
        ret_pulse <= 1'b0;
        wb(1'b0, 8'h04, s);
    endtask
    // Key pulse followed by n retired instructions.
    task key(input int n);
        unlock <= 1'b1;
        @(posedge core_clk);
        unlock <= 1'b0;
        if (n > 0) begin
            retire <= 1'b1;
            repeat (n) @(posedge core_clk);
            retire <= 1'b0;
        end
    endtask
    // Main sequence: registers, arbitration, nesting, round robin, protection, compact table.
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int k = 0; k < 5; k++) wb(1'b0, 8'(k * 4), 8'h00);
        wb(1'b1, 8'h00, 8'h61);
        wb(1'b0, 8'h00, 8'h01);
        wb(1'b1, 8'h00, 8'h00);
        rnd = $random(seed);
        wb(1'b1, 8'h08, rnd[7:0]);
        wb(1'b0, 8'h08, rnd[7:0]);
        wb(1'b1, 8'h0C, rnd[15:8]);
        wb(1'b0, 8'h0C, rnd[15:8]);
        wb(1'b1, 8'h0C, 8'h00);
        wb(1'b1, 8'h08, 8'h00);
        lane = 4'h0;
        wb(1'b1, 8'h08, 8'h55);
        lane = 4'h1;
        wb(1'b0, 8'h08, 8'h00);
        gie <= 1'b1;
        irq_go(32'h0000_0028, {CIP_LV_NORM, 8'h03});
        wb(1'b0, 8'h04, 8'h01);
        irq <= 32'h0000_0000;
        ret_chk(8'h00);
        wb(1'b1, 8'h08, 8'h03);
        irq_go(32'h0000_0028, {CIP_LV_NORM, 8'h05});
        wb(1'b1, 8'h0C, 8'h05);
        irq_go(32'h0000_0028, {CIP_LV_HIGH, 8'h05});
        wb(1'b0, 8'h04, 8'h03);
        irq_go(32'h0000_002A, {CIP_LV_NMI, 8'h01});
        wb(1'b0, 8'h04, 8'h83);
        irq <= 32'h0000_0000;
        ret_chk(8'h03);
        ret_chk(8'h01);
        ret_chk(8'h00);
        wb(1'b1, 8'h0C, 8'h00);
        wb(1'b1, 8'h00, 8'h01);
        wb(1'b1, 8'h08, 8'h00);
        irq_go(32'h0000_0028, {CIP_LV_NORM, 8'h03});
        irq <= 32'h0000_0000;
        wb(1'b0, 8'h08, 8'h03);
        ret_chk(8'h00);
        key(0);
        wb(1'b1, 8'h00, 8'h61);
        wb(1'b0, 8'h00, 8'h61);
        chk("base", {9'h000, vbb}, 10'h001);
        boot_all <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("base", {9'h000, vbb}, 10'h000);
        key(4);
        wb(1'b1, 8'h00, 8'h01);
        wb(1'b0, 8'h00, 8'h61);
        key(3);
        wb(1'b1, 8'h00, 8'h21);
        wb(1'b0, 8'h00, 8'h21);
        irq_go(32'h0000_0020, {CIP_LV_NORM, 8'h03});
        wb(1'b1, 8'h0C, 8'h05);
        irq_go(32'h0000_0020, {CIP_LV_HIGH, 8'h02});
        gie <= 1'b0;
        irq_go(32'h0000_0022, {CIP_LV_NMI, 8'h01});
        irq <= 32'h0000_0000;
        ret_chk(8'h03);
        ret_chk(8'h01);
        ret_chk(8'h00);
        stop_test();
    end
endmodule // cip_ctrl_tb
`default_nettype wire
